/* File: dv/lbf_far_end.sv */
`default_nettype none
module lbf_far_end
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset_n,
  input  wire logic        i_mod,
  input  wire logic        i_env,
  input  wire logic [15:0] i_drop,
  output logic             o_line,
  output logic             o_env
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_r;
  // ----------------------------------------
  // line driver, pair and receive comparators
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cnt_r  <= 16'h0000;
      o_line <= 1'b0;
      o_env  <= 1'b0;
    end
    else
    begin
      cnt_r  <= i_env ? cnt_r + 16'h0001 : 16'h0000;
      // no signal on the pair: the limiter output wanders
      o_line <= i_env ? i_mod : ~o_line;
      // window detector, optionally with one dropout mid burst
      o_env  <= i_env && !(cnt_r >= 16'h00c8 && cnt_r < 16'h00c8 + i_drop);
    end
  end
endmodule
`default_nettype wire

/* File: dv/lbf_loop_burst_framer_monitor.sv */
`default_nettype none
module lbf_loop_burst_framer_monitor
  import lbf_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_master_mode,
  input wire logic i_master_data_clock,
  input wire logic i_slave_clock,
  input wire logic i_frame_sync_in,
  input wire logic i_transfer_enable,
  input wire logic i_shift_in_enable,
  input wire logic i_serial_in,
  input wire logic i_line_flag_in_a,
  input wire logic i_line_flag_in_b,
  input wire logic i_limited_line_in,
  input wire logic i_burst_envelope_in,
  input wire logic o_mod_data,
  input wire logic o_modulation_envelope_out,
  input wire logic o_serial_out,
  input wire logic o_line_flag_out_a,
  input wire logic o_line_flag_out_b,
  input wire logic o_tx_ready,
  input wire logic o_burst_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WORD_CYC = BIT_CYC_INT * WORD_W;
  logic [3:0]  prv_r;
  logic [15:0] hi_r;
  logic [15:0] lo_r;
  logic [15:0] same_r;
  logic [15:0] since_r;
  logic        env;
  logic        load;
  logic        shift;
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  assign env   = o_modulation_envelope_out;
  assign load  = i_master_mode ? i_frame_sync_in && !prv_r[3]
                               : i_transfer_enable && !prv_r[2];
  assign shift = i_transfer_enable && (i_master_mode ? i_master_data_clock && !prv_r[1]
                                                     : i_slave_clock && !prv_r[0]);
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      prv_r   <= 4'h0;
      hi_r    <= 16'h0000;
      lo_r    <= 16'h0000;
      same_r  <= 16'h0000;
      since_r <= 16'hffff;
    end
    else
    begin
      prv_r   <= {i_frame_sync_in, i_transfer_enable, i_master_data_clock, i_slave_clock};
      hi_r    <= env ? hi_r + 16'h0001 : 16'h0000;
      lo_r    <= env ? 16'h0000 : lo_r + 16'(lo_r < 16'h0010);
      same_r  <= $stable(o_mod_data) ? same_r + 16'h0001 : 16'h0000;
      // a new burst is only taken once the previous one is over
      since_r <= ($rose(i_burst_envelope_in) && since_r >= 16'h0616) ? 16'h0000
               : since_r + 16'(since_r != 16'hffff);
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_reset_n);
  sequence s_idle_load;
    load && !env && lo_r >= 16'h0004 && !$past(load, 2);
  endsequence
  sequence s_env_up;
    ##2 !env ##1 env;
  endsequence
  env_start_a: assert property (s_idle_load |-> s_env_up)
    else $error("envelope start off");
  env_len_a: assert property ($fell(env) |-> hi_r != 16'h0000 && hi_r % WORD_CYC == 0)
    else $error("envelope length off");
  mod_run_a: assert property (same_r <= 16'h009c)
    else $error("modulated data stuck");
  flag_a_hold_a: assert property ($changed(o_line_flag_out_a) |-> $past(load))
    else $error("flag a moved without load");
  flag_b_hold_a: assert property ($changed(o_line_flag_out_b) |-> $past(load))
    else $error("flag b moved without load");
  ready_fall_a: assert property ($fell(o_tx_ready) |-> $past(load))
    else $error("ready fell without load");
  ser_shift_a: assert property ($changed(o_serial_out) |-> $past(shift))
    else $error("serial out moved without shift");
  valid_time_a: assert property ($changed(o_burst_valid) |-> since_r inside {[16'h0614:16'h061e]})
    else $error("burst judgement mistimed");
endmodule
bind lbf_loop_burst_framer lbf_loop_burst_framer_monitor u_mon (.*);
`default_nettype wire

/* File: dv/lbf_loop_burst_framer_tb_top.sv */
`default_nettype none
module lbf_loop_burst_framer_tb_top
  import lbf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WORD_CYC = BIT_CYC_INT * WORD_W;
  logic        i_clk_sys;
  logic        i_reset_n;
  logic        mode, mclk, sclk, fs, te, sie, sin, fa, fb, pa, pb;
  logic [7:0]  last_d;
  logic [15:0] drop;
  wire logic   line, benv, mod, env, sout, foa, fob, rdy, bval;
  int          errors;
  int          num_checks;
  int          high_n;
  lbf_loop_burst_framer dut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_master_mode(mode), .i_master_data_clock(mclk), .i_slave_clock(sclk),
    .i_frame_sync_in(fs), .i_transfer_enable(te), .i_shift_in_enable(sie),
    .i_serial_in(sin), .i_line_flag_in_a(fa), .i_line_flag_in_b(fb),
    .i_limited_line_in(line), .i_burst_envelope_in(benv), .o_mod_data(mod),
    .o_modulation_envelope_out(env), .o_serial_out(sout), .o_line_flag_out_a(foa),
    .o_line_flag_out_b(fob), .o_tx_ready(rdy), .o_burst_valid(bval));
  lbf_far_end far (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_mod(mod),
    .i_env(env), .i_drop(drop), .o_line(line), .o_env(benv));
  initial
  begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic step(input var int n);
    repeat (n) @(posedge i_clk_sys);
    #2;
  endtask
  task automatic tick();
    step(1);
    high_n += int'(env === 1'b1);
  endtask
  task automatic check(input var logic [15:0] seen, input var logic [15:0] exp,
                       input string what);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic clk_pulse();
    mclk = mode;
    sclk = !mode;
    step(3);
    mclk = 1'b0;
    sclk = 1'b0;
    step(3);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one word out and back over the pair, then a second load and a read-out
  task automatic frame(input var logic m, input var logic [7:0] d, input var logic a,
                       input var logic b, input var logic [15:0] dr);
    int   n;
    logic ok;
    ok   = dr <= 16'(DROP_MAX);
    mode = m;
    drop = dr;
    fa   = a;
    fb   = b;
    sie  = 1'b1;
    for (int i = 7; i >= 0; i--)
    begin
      sin = d[i];
      clk_pulse();
    end
    sie = 1'b0;
    fs  = 1'b1;
    te  = 1'b1;
    step(2);
    fs = 1'b0;
    check(16'(env), 16'h0000, "env early");
    step(1);
    check(16'(env), 16'h0001, "env start");
    n = 0;
    while (env === 1'b1 && n < 2000)
    begin
      n++;
      step(1);
    end
    check(16'(n), 16'(WORD_CYC), "env length");
    te = 1'b0;
    step(60);
    check(16'(bval), 16'(ok), "burst valid");
    check(16'({foa, fob}), 16'({pa, pb}), "flags held");
    if (ok)
      {pa, pb, last_d} = {a, b, d};
    drop = 16'h0000;
    fs   = 1'b1;
    te   = 1'b1;
    step(2);
    fs = 1'b0;
    check(16'({foa, fob}), 16'({pa, pb}), "flags new");
    for (int i = 7; i >= 0; i--)
    begin
      clk_pulse();
      check(16'(sout), 16'(last_d[i]), "serial out");
    end
    te = 1'b0;
    step(WORD_CYC + 100);
    {pa, pb, last_d} = {a, b, d};
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic sc_master();
    frame(1'b1, 8'ha5, 1'b1, 1'b0, 16'h012c);
  endtask
  task automatic sc_drop();
    frame(1'b1, 8'h3c, 1'b0, 1'b1, 16'h01e0);
  endtask
  task automatic sc_fifo();
    high_n = 0;
    for (int i = 0; i < 10; i++)
    begin
      fs = 1'b1;
      tick();
      fs = 1'b0;
      tick();
      if (i >= 7 && i <= 8)
        check(16'(rdy), 16'(i == 7), "tx ready");
    end
    repeat (9 * WORD_CYC + 300) tick();
    check(16'(high_n), 16'(9 * WORD_CYC), "burst train");
    {pa, pb} = {fa, fb};
  endtask
  task automatic sc_slave();
    frame(1'b0, 8'h5a, 1'b1, 1'b1, 16'h0000);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {i_reset_n, mode, mclk, sclk, fs, te, sie, sin, fa, fb, pa, pb} = 12'h000;
    last_d     = 8'h00;
    drop       = 16'h0000;
    errors     = 0;
    num_checks = 0;
    high_n     = 0;
    step(20);
    check(16'({env, sout, foa, fob, bval, rdy}), 16'h0001, "reset");
    i_reset_n = 1'b1;
    step(2);
    sc_master();
    sc_drop();
    sc_fifo();
    sc_slave();
    finish_test();
  end
  initial
  begin
    repeat (60000) @(posedge i_clk_sys);
    errors++;
    finish_test();
  end
endmodule
`default_nettype wire

/* File: src/lbf_demod.sv */
`default_nettype none
module lbf_demod
  import lbf_pkg::*;
(
  input  wire logic              i_clk_sys,
  input  wire logic              i_reset_n,
  input  wire logic              i_line,
  input  wire logic              i_env,
  output logic [WORD_W-1:0]      o_word,
  output logic                   o_done,
  output logic                   o_valid
);
  logic              env_q_r;
  logic              busy_r;
  logic [7:0]        cyc_r;
  logic [3:0]        idx_r;
  logic              s_prev_r;
  logic [WORD_W-1:0] sr_r;
  logic [11:0]       low_cnt_r;
  logic              start;

  assign start  = i_env & ~env_q_r & ~busy_r;
  assign o_word = sr_r;

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      env_q_r   <= 1'b0;
      busy_r    <= 1'b0;
      cyc_r     <= CYC_RST;
      idx_r     <= IDX_RST;
      s_prev_r  <= 1'b0;
      sr_r      <= WORD_RST;
      low_cnt_r <= CNT12_RST;
      o_done    <= 1'b0;
      o_valid   <= 1'b0;
    end
    else
    begin
      env_q_r <= i_env;
      o_done  <= 1'b0;
      if (start)
      begin
        busy_r    <= 1'b1;
        cyc_r     <= CYC_RST;
        idx_r     <= IDX_RST;
        s_prev_r  <= 1'b0;
        low_cnt_r <= CNT12_RST;
      end
      else if (busy_r)
      begin
        if (!i_env)
        begin
          low_cnt_r <= low_cnt_r + 1'b1;
        end
        // differential: a phase flip against the previous bit is a one
        if (cyc_r == QTR_CYC)
        begin
          sr_r     <= {sr_r[WORD_W-2:0], i_line ^ s_prev_r};
          s_prev_r <= i_line;
        end
        if (cyc_r == BIT_LAST)
        begin
          cyc_r <= CYC_RST;
          idx_r <= idx_r + 1'b1;
          if (idx_r == WORD_LAST)
          begin
            busy_r  <= 1'b0;
            o_done  <= 1'b1;
            o_valid <= (low_cnt_r <= DROP_MAX);
          end
        end
        else
        begin
          cyc_r <= cyc_r + 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: src/lbf_fifo.sv */
`default_nettype none
module lbf_fifo
  import lbf_pkg::*;
#(
  parameter int unsigned W     = 10,
  parameter int unsigned DEPTH = 8
)
(
  input  wire logic         i_clk_sys,
  input  wire logic         i_reset_n,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [CW-1:0] cnt_r;
  logic          push;
  logic          pop;

  assign o_in_ready  = (cnt_r != CNT_FULL);
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data  = mem[rd_ptr_r];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always_ff @(posedge i_clk_sys)
  begin
    if (push)
    begin
      mem[wr_ptr_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= (wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_r <= cnt_r + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: src/lbf_loop_burst_framer.sv */
`default_nettype none
module lbf_loop_burst_framer
  import lbf_pkg::*;
(
  input  wire logic i_clk_sys,
  input  wire logic i_reset_n,
  input  wire logic i_master_mode,
  input  wire logic i_master_data_clock,
  input  wire logic i_slave_clock,
  input  wire logic i_frame_sync_in,
  input  wire logic i_transfer_enable,
  input  wire logic i_shift_in_enable,
  input  wire logic i_serial_in,
  input  wire logic i_line_flag_in_a,
  input  wire logic i_line_flag_in_b,
  input  wire logic i_limited_line_in,
  input  wire logic i_burst_envelope_in,
  output logic      o_mod_data,
  output logic      o_modulation_envelope_out,
  output logic      o_serial_out,
  output logic      o_line_flag_out_a,
  output logic      o_line_flag_out_b,
  output logic      o_tx_ready,
  output logic      o_burst_valid
);
  // -------------------------------------------------------------
  // helper functions
  // -------------------------------------------------------------
  // rising edge of a sampled strobe against its previous sample
  function automatic logic rise_f
  (
    input var logic cur,
    input var logic prev
  );
    return cur & ~prev;
  endfunction

  // payload registers shift towards the msb, new bit at the lsb
  function automatic logic [PAY_W-1:0] shl_f
  (
    input var logic [PAY_W-1:0] val,
    input var logic             bit_in
  );
    return {val[PAY_W-2:0], bit_in};
  endfunction

  // -------------------------------------------------------------
  // edge detection of host strobes
  // -------------------------------------------------------------
  logic mclk_q_r;
  logic sclk_q_r;
  logic fsync_q_r;
  logic ten_q_r;
  logic shift_edge;
  logic load_edge;

  // shift clocks
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      mclk_q_r <= 1'b0;
      sclk_q_r <= 1'b0;
    end
    else
    begin
      mclk_q_r <= i_master_data_clock;
      sclk_q_r <= i_slave_clock;
    end
  end

  // load strobes; reset level matches their idle level, so no false edge
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      fsync_q_r <= 1'b0;
      ten_q_r   <= 1'b0;
    end
    else
    begin
      fsync_q_r <= i_frame_sync_in;
      ten_q_r   <= i_transfer_enable;
    end
  end

  always_comb
  begin
    if (i_master_mode)
    begin
      shift_edge = rise_f(i_master_data_clock, mclk_q_r);
      load_edge  = rise_f(i_frame_sync_in, fsync_q_r);
    end
    else
    begin
      shift_edge = rise_f(i_slave_clock, sclk_q_r);
      load_edge  = rise_f(i_transfer_enable, ten_q_r);
    end
  end

  // -------------------------------------------------------------
  // transmit shift register
  // -------------------------------------------------------------
  logic [PAY_W-1:0] tx_sr_r;
  logic             tx_shift;

  assign tx_shift = shift_edge & i_shift_in_enable;

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      tx_sr_r <= PAY_RST;
    end
    else if (tx_shift)
    begin
      tx_sr_r <= shl_f(tx_sr_r, i_serial_in);
    end
  end

  // -------------------------------------------------------------
  // modulation buffer (fifo)
  // -------------------------------------------------------------
  logic [WORD_W-1:0] load_word;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic              fifo_out_ready;
  logic [WORD_W-1:0] fifo_out_data;

  // payload and both flags are taken on the same edge
  assign load_word  = {tx_sr_r, i_line_flag_in_a, i_line_flag_in_b};
  assign o_tx_ready = fifo_in_ready;

  lbf_fifo #(
    .W     (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (load_edge),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (load_word),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (fifo_out_ready),
    .o_out_data  (fifo_out_data)
  );

  // -------------------------------------------------------------
  // modulator
  // -------------------------------------------------------------
  lbf_tx_state_t     tx_state_r;
  logic [7:0]        tx_cyc_r;
  logic [3:0]        tx_idx_r;
  logic [WORD_W-1:0] tx_word_r;
  logic              phase_r;
  logic              mod_r;
  logic              env_r;

  assign fifo_out_ready = (tx_state_r == TX_IDLE);

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      tx_state_r <= TX_IDLE;
      tx_cyc_r   <= CYC_RST;
      tx_idx_r   <= IDX_RST;
      tx_word_r  <= WORD_RST;
      phase_r    <= 1'b0;
    end
    else
    begin
      unique case (tx_state_r)
        TX_IDLE:
        begin
          // carrier keeps running between bursts
          tx_cyc_r <= (tx_cyc_r == BIT_LAST) ? CYC_RST : tx_cyc_r + 1'b1;
          if (fifo_out_valid)
          begin
            tx_state_r <= TX_SEND;
            tx_cyc_r   <= CYC_RST;
            tx_idx_r   <= IDX_RST;
            tx_word_r  <= fifo_out_data;
            phase_r    <= fifo_out_data[WORD_W-1];
          end
        end
        TX_SEND:
        begin
          if (tx_cyc_r == BIT_LAST)
          begin
            tx_cyc_r  <= CYC_RST;
            tx_word_r <= {tx_word_r[WORD_W-2:0], 1'b0};
            if (tx_idx_r == WORD_LAST)
            begin
              tx_state_r <= TX_IDLE;
            end
            else
            begin
              tx_idx_r <= tx_idx_r + 1'b1;
              phase_r  <= phase_r ^ tx_word_r[WORD_W-2];
            end
          end
          else
          begin
            tx_cyc_r <= tx_cyc_r + 1'b1;
          end
        end
      endcase
    end
  end

  // line output and envelope share one register stage so they stay aligned
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      mod_r <= 1'b0;
      env_r <= 1'b0;
    end
    else
    begin
      mod_r <= phase_r ^ (tx_cyc_r >= HALF_CYC);
      env_r <= (tx_state_r == TX_SEND);
    end
  end

  // external driver gates line legs with the envelope
  assign o_mod_data                = mod_r;
  assign o_modulation_envelope_out = env_r;

  // -------------------------------------------------------------
  // demodulator and burst judgement
  // -------------------------------------------------------------
  logic [WORD_W-1:0] dem_word;
  logic              dem_done;
  logic              dem_valid;
  logic              rx_load;

  lbf_demod u_demod (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_line    (i_limited_line_in),
    .i_env     (i_burst_envelope_in),
    .o_word    (dem_word),
    .o_done    (dem_done),
    .o_valid   (dem_valid)
  );

  // an invalid burst leaves receive register and flags untouched
  assign rx_load = dem_done & dem_valid;

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_burst_valid <= 1'b0;
    end
    else if (dem_done)
    begin
      o_burst_valid <= dem_valid;
    end
  end

  // -------------------------------------------------------------
  // received flags, held until the next load edge
  // -------------------------------------------------------------
  logic flag_a_pend_r;
  logic flag_b_pend_r;

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      flag_a_pend_r <= 1'b0;
      flag_b_pend_r <= 1'b0;
    end
    else if (rx_load)
    begin
      flag_a_pend_r <= dem_word[FLAG_A_POS];
      flag_b_pend_r <= dem_word[FLAG_B_POS];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_line_flag_out_a <= 1'b0;
      o_line_flag_out_b <= 1'b0;
    end
    else if (load_edge)
    begin
      o_line_flag_out_a <= flag_a_pend_r;
      o_line_flag_out_b <= flag_b_pend_r;
    end
  end

  // -------------------------------------------------------------
  // receive register and serial output
  // -------------------------------------------------------------
  logic [PAY_W-1:0] rx_sr_r;
  logic             rx_shift;

  assign rx_shift = shift_edge & i_transfer_enable;

  // a fresh word overrides a shift in the same cycle
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rx_sr_r <= PAY_RST;
    end
    else if (rx_load)
    begin
      rx_sr_r <= dem_word[PAY_MSB:PAY_LSB];
    end
    else if (rx_shift)
    begin
      rx_sr_r <= shl_f(rx_sr_r, 1'b0);
    end
  end

  // the pin follows only shifts that the register really made
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_serial_out <= 1'b0;
    end
    else if (rx_shift && !rx_load)
    begin
      o_serial_out <= rx_sr_r[PAY_W-1];
    end
  end
endmodule
`default_nettype wire

/* File: src/lbf_pkg.sv */
`default_nettype none
package lbf_pkg;
  // -------------------------------------------------------------
  // timing
  // -------------------------------------------------------------
  localparam int unsigned CLK_HZ            = 40_000_000;
  localparam int unsigned LINE_BIT_RATE_BPS = 256_000;
  localparam int unsigned BIT_CYC_INT       = CLK_HZ / LINE_BIT_RATE_BPS;
  localparam logic [7:0]  BIT_CYC           = 8'(BIT_CYC_INT);
  localparam logic [7:0]  BIT_LAST          = 8'(BIT_CYC_INT - 1);
  localparam logic [7:0]  HALF_CYC          = 8'(BIT_CYC_INT / 2);
  localparam logic [7:0]  QTR_CYC           = 8'(BIT_CYC_INT / 4);
  // -------------------------------------------------------------
  // word layout
  // -------------------------------------------------------------
  localparam int unsigned PAY_W      = 8;
  localparam int unsigned WORD_W     = 10;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned PAY_MSB    = 9;
  localparam int unsigned PAY_LSB    = 2;
  localparam int unsigned FLAG_A_POS = 1;
  localparam int unsigned FLAG_B_POS = 0;
  localparam logic [3:0]  WORD_LAST  = 4'(WORD_W - 1);
  // -------------------------------------------------------------
  // burst quality
  // -------------------------------------------------------------
  localparam int unsigned DROP_PCT   = 25;
  localparam logic [11:0] DROP_MAX   = 12'(WORD_W * BIT_CYC_INT * DROP_PCT / 100);
  // -------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------
  localparam logic [7:0]  PAY_RST    = 8'h00;
  localparam logic [9:0]  WORD_RST   = 10'h000;
  localparam logic [11:0] CNT12_RST  = 12'h000;
  localparam logic [7:0]  CYC_RST    = 8'h00;
  localparam logic [3:0]  IDX_RST    = 4'h0;

  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } lbf_tx_state_t;
endpackage
`default_nettype wire
